// ===== shared/usbsi_pkg.sv
// Function
// - Reset condition asserts status during bus reset
// - Suspend condition asserts status while suspended
// - Power condition asserts when current draw unsafe
// - Low-power descriptor: power condition means suspended
// - High-power: suspended or not yet configured
// - Register selects polarity and status conditions
// - Deassert when no selected condition holds
// - Reset default: active high, suspend only
// - Multi-function pins reset to pulled-up inputs
// - Receive indicator toggles ~10Hz only while receiving
// - Transmit indicator toggles ~10Hz only while transmitting
// - One pin switchable to half-duplex direction
// - One pin switchable to clock output
package usbsi_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_STAT_CFG  = 8'h00;
  localparam logic [7:0] OFS_MAX_POWER = 8'h04;
  localparam logic [7:0] OFS_USB_STATE = 8'h08;
  localparam logic [7:0] OFS_PIN_FUNC  = 8'h0c;
  localparam logic [7:0] OFS_GPIO_DIR  = 8'h10;
  localparam logic [7:0] OFS_GPIO_OUT  = 8'h14;
  localparam logic [7:0] OFS_GPIO_PULL = 8'h18;
  localparam logic [7:0] OFS_GPIO_IN   = 8'h1c;

  // Status config field positions
  localparam int CFG_POL_BIT   = 0;
  localparam int CFG_RESET_BIT = 1;
  localparam int CFG_SUSP_BIT  = 2;
  localparam int CFG_POWER_BIT = 3;

  // Pin indices within the 4-pin group (io6..io9)
  localparam int PIN_CLK = 0;
  localparam int PIN_DIR = 1;
  localparam int PIN_TXA = 2;
  localparam int PIN_RXA = 3;

  // Reset values
  localparam logic [3:0] RST_STAT_CFG  = 4'h5;
  localparam logic [7:0] RST_MAX_POWER = 8'h32;
  localparam logic [3:0] RST_PIN_FUNC  = 4'h0;
  localparam logic [3:0] RST_GPIO_DIR  = 4'h0;
  localparam logic [3:0] RST_GPIO_OUT  = 4'h0;
  localparam logic [3:0] RST_GPIO_PULL = 4'hf;

  // One unit load limit in 2 mA units
  localparam logic [7:0] UNIT_LOAD_LIMIT = 8'h32;

  // Activity indicator timing
  localparam int CLK_KHZ        = 100000;
  localparam int ACT_TOGGLE_MS  = 100;
  localparam int ACT_TOGGLE_CYC = ACT_TOGGLE_MS * CLK_KHZ;

  typedef enum logic [0:0]
  {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } usbsi_bus_t;

endpackage

// ===== shared/usbsi_blink_if.sv
interface usbsi_blink_if;
  logic busy;
  logic level;

  modport owner
  (
    output busy,
    input  level
  );

  modport blinker
  (
    input  busy,
    output level
  );
endinterface

// ===== hdl/usbsi_blink.sv
module usbsi_blink
  import usbsi_pkg::*;
#(
  parameter int TOGGLE_CYC = ACT_TOGGLE_CYC
)
(
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          nrst,
  // Activity link
  usbsi_blink_if.blinker    act
);

  // Refused at elaboration: the counter needs two states
  if (TOGGLE_CYC < 2)
  begin
    $error("usbsi_blink: TOGGLE_CYC must be at least 2");
  end

  logic [31:0] cnt_r;
  logic        level_r;

  // Counter restarts when idle so every burst begins with a full interval
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= 32'h0;
    else if (!act.busy)
      cnt_r <= 32'h0;
    else if (cnt_r == 32'(TOGGLE_CYC - 1))
      cnt_r <= 32'h0;
    else
      cnt_r <= cnt_r + 32'h1;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      level_r <= 1'b0;
    else if (act.busy && cnt_r == 32'(TOGGLE_CYC - 1))
      level_r <= ~level_r;
  end

  assign act.level = level_r;

endmodule

// ===== hdl/usbsi_top.sv
// The Avalon-MM slave port and the register offsets are this design's own decisions.
module usbsi_top
  import usbsi_pkg::*;
#(
  parameter int TOGGLE_CYC = ACT_TOGGLE_CYC
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // USB core state
  input  wire logic        usb_bus_reset,
  input  wire logic        usb_suspended,
  input  wire logic        usb_configured,
  // UART activity and alternate sources
  input  wire logic        uart_rx_busy,
  input  wire logic        uart_tx_busy,
  input  wire logic        uart_dir_ctl,
  input  wire logic        clk_pulse_src,
  // Status pin
  output logic             usb_status_out,
  // Multi-function pins io6..io9
  input  wire logic [3:0]  port_b_io_in,
  output logic      [3:0]  port_b_io_out,
  output logic      [3:0]  port_b_io_oe,
  output logic      [3:0]  port_b_io_pullup
);

  // Refused at elaboration: the blinkers need two states
  if (TOGGLE_CYC < 2)
  begin
    $error("usbsi_top: TOGGLE_CYC must be at least 2");
  end

  // Register state
  logic [3:0]  stat_cfg_r;
  logic [7:0]  max_power_r;
  logic [3:0]  pin_func_r;
  logic [3:0]  gpio_dir_r;
  logic [3:0]  gpio_out_r;
  logic [3:0]  gpio_pull_r;

  // Bus handshake
  usbsi_bus_t  bus_r;
  usbsi_bus_t  bus_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        req;
  logic        wr_take;

  // Pin input synchroniser
  logic [3:0]  pin_meta_r;
  logic [3:0]  pin_sync_r;

  // Status path
  logic        power_unsafe;
  logic        cond_any;
  logic        status_r;

  // Activity indicators
  usbsi_blink_if rx_act ();
  usbsi_blink_if tx_act ();

  // Pin drive
  logic [3:0]  alt_val;
  logic [3:0]  pin_out_r;
  logic [3:0]  pin_oe_r;
  logic [3:0]  pin_pull_r;

  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    wr_hit = addr == ofs;
  endfunction

  function automatic logic [31:0] zext4(input logic [3:0] v);
    zext4 = {28'h0, v};
  endfunction

  // One wait cycle: request seen, answered on the following edge
  assign req     = avs_read | avs_write;
  assign wr_take = avs_write && bus_r == BUS_ACK && avs_byteenable[0];

  always_comb
  begin
    bus_nxt = BUS_IDLE;
    case (bus_r)
      BUS_IDLE:
      begin
        if (req)
          bus_nxt = BUS_ACK;
      end
      BUS_ACK:
      begin
        bus_nxt = BUS_IDLE;
      end
      default:
      begin
        bus_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      bus_r <= BUS_IDLE;
    else
      bus_r <= bus_nxt;
  end

  assign avs_waitrequest = req && bus_r == BUS_IDLE;

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = 32'h0;
    case (avs_address)
      OFS_STAT_CFG:
      begin
        rdata_nxt = zext4(stat_cfg_r);
      end
      OFS_MAX_POWER:
      begin
        rdata_nxt = {24'h0, max_power_r};
      end
      OFS_USB_STATE:
      begin
        rdata_nxt = zext4({status_r, usb_configured, usb_suspended, usb_bus_reset});
      end
      OFS_PIN_FUNC:
      begin
        rdata_nxt = zext4(pin_func_r);
      end
      OFS_GPIO_DIR:
      begin
        rdata_nxt = zext4(gpio_dir_r);
      end
      OFS_GPIO_OUT:
      begin
        rdata_nxt = zext4(gpio_out_r);
      end
      OFS_GPIO_PULL:
      begin
        rdata_nxt = zext4(gpio_pull_r);
      end
      OFS_GPIO_IN:
      begin
        rdata_nxt = zext4(pin_sync_r);
      end
      default:
      begin
        rdata_nxt = 32'h0;
      end
    endcase
  end

  // Captured in the wait cycle, so stable at the answering edge
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 32'h0;
    else if (avs_read && bus_r == BUS_IDLE)
      rdata_r <= rdata_nxt;
  end

  assign avs_readdata = rdata_r;

  // Status configuration
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      stat_cfg_r <= RST_STAT_CFG;
    else if (wr_take && wr_hit(avs_address, OFS_STAT_CFG))
      stat_cfg_r <= avs_writedata[3:0];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      max_power_r <= RST_MAX_POWER;
    else if (wr_take && wr_hit(avs_address, OFS_MAX_POWER))
      max_power_r <= avs_writedata[7:0];
  end

  // Pin function and GPIO registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pin_func_r <= RST_PIN_FUNC;
    else if (wr_take && wr_hit(avs_address, OFS_PIN_FUNC))
      pin_func_r <= avs_writedata[3:0];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      gpio_dir_r <= RST_GPIO_DIR;
    else if (wr_take && wr_hit(avs_address, OFS_GPIO_DIR))
      gpio_dir_r <= avs_writedata[3:0];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      gpio_out_r <= RST_GPIO_OUT;
    else if (wr_take && wr_hit(avs_address, OFS_GPIO_OUT))
      gpio_out_r <= avs_writedata[3:0];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      gpio_pull_r <= RST_GPIO_PULL;
    else if (wr_take && wr_hit(avs_address, OFS_GPIO_PULL))
      gpio_pull_r <= avs_writedata[3:0];
  end

  // Pins are asynchronous to core_clk
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end
    else
    begin
      pin_meta_r <= port_b_io_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Power condition follows the descriptor's current request
  always_comb
  begin
    if (max_power_r > UNIT_LOAD_LIMIT)
      power_unsafe = usb_suspended | ~usb_configured;
    else
      power_unsafe = usb_suspended;
  end

  always_comb
  begin
    cond_any = 1'b0;
    if (stat_cfg_r[CFG_RESET_BIT] && usb_bus_reset)
      cond_any = 1'b1;
    if (stat_cfg_r[CFG_SUSP_BIT] && usb_suspended)
      cond_any = 1'b1;
    if (stat_cfg_r[CFG_POWER_BIT] && power_unsafe)
      cond_any = 1'b1;
  end

  // Registered so the pin never glitches while conditions settle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      status_r <= 1'b0;
    else
      status_r <= stat_cfg_r[CFG_POL_BIT] ? cond_any : ~cond_any;
  end

  assign usb_status_out = status_r;

  // Activity blinkers
  assign rx_act.busy = uart_rx_busy;
  assign tx_act.busy = uart_tx_busy;

  usbsi_blink #(
    .TOGGLE_CYC (TOGGLE_CYC)
  ) u_rx_blink (
    .core_clk (core_clk),
    .nrst     (nrst),
    .act      (rx_act.blinker)
  );

  usbsi_blink #(
    .TOGGLE_CYC (TOGGLE_CYC)
  ) u_tx_blink (
    .core_clk (core_clk),
    .nrst     (nrst),
    .act      (tx_act.blinker)
  );

  // Alternate function sources per pin
  always_comb
  begin
    alt_val          = 4'h0;
    alt_val[PIN_CLK] = clk_pulse_src;
    alt_val[PIN_DIR] = uart_dir_ctl;
    alt_val[PIN_TXA] = tx_act.level;
    alt_val[PIN_RXA] = rx_act.level;
  end

  // Alternate functions drive push-pull with pull-up released
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out_r  <= 4'h0;
      pin_oe_r   <= 4'h0;
      pin_pull_r <= RST_GPIO_PULL;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (pin_func_r[i])
        begin
          pin_out_r[i]  <= alt_val[i];
          pin_oe_r[i]   <= 1'b1;
          pin_pull_r[i] <= 1'b0;
        end
        else
        begin
          pin_out_r[i]  <= gpio_out_r[i];
          pin_oe_r[i]   <= gpio_dir_r[i];
          pin_pull_r[i] <= gpio_pull_r[i] & ~gpio_dir_r[i];
        end
      end
    end
  end

  assign port_b_io_out    = pin_out_r;
  assign port_b_io_oe     = pin_oe_r;
  assign port_b_io_pullup = pin_pull_r;

endmodule

// ===== sim/usbsi_board.sv
module usbsi_board
(
  // Pin drive from the block
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  input  wire logic [3:0] io_pull,
  // Level seen back at the pins
  output logic      [3:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Weak board pull-down: a floating pin never keeps its old level
  always_comb
    for (int k = 0; k < 4; k++)
      io_in[k] = io_oe[k] ? io_out[k] : io_pull[k];
endmodule

// ===== sim/usbsi_monitor.sv
module usbsi_monitor
  import usbsi_pkg::*;
#(
  parameter int TOGGLE_CYC = ACT_TOGGLE_CYC
)
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // Register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Sources
  input wire logic        usb_bus_reset,
  input wire logic        usb_suspended,
  input wire logic        usb_configured,
  input wire logic        uart_rx_busy,
  input wire logic        uart_tx_busy,
  input wire logic        uart_dir_ctl,
  input wire logic        clk_pulse_src,
  // Pins
  input wire logic        usb_status_out,
  input wire logic [3:0]  port_b_io_in,
  input wire logic [3:0]  port_b_io_out,
  input wire logic [3:0]  port_b_io_oe,
  input wire logic [3:0]  port_b_io_pullup
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cfg_r;
  logic [7:0] mp_r;
  logic [3:0] fn_r;
  logic       wr_ok;
  logic       cond;
  logic       st_exp;

  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign cond = (cfg_r[1] && usb_bus_reset) || (cfg_r[2] && usb_suspended) || (cfg_r[3]
    && (usb_suspended || (mp_r > UNIT_LOAD_LIMIT && !usb_configured)));
  assign st_exp = cfg_r[0] ? cond : !cond;

  // Shadow taken at the accepting edge, same moment the block updates
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      cfg_r <= RST_STAT_CFG;
      mp_r  <= RST_MAX_POWER;
      fn_r  <= RST_PIN_FUNC;
    end
    else if (wr_ok)
    begin
      if (avs_address == OFS_STAT_CFG)
        cfg_r <= avs_writedata[3:0];
      if (avs_address == OFS_MAX_POWER)
        mp_r <= avs_writedata[7:0];
      if (avs_address == OFS_PIN_FUNC)
        fn_r <= avs_writedata[3:0];
    end

  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Sampled nrst gates the release edge, where the pin still shows its reset level
  chk_status_map: assert property (nrst |=> usb_status_out == $past(st_exp))
    else $error("status pin differs from selected conditions");
  chk_reset_cond: assert property (nrst && cfg_r[1] && cfg_r[0]
    && usb_bus_reset |=> usb_status_out)
    else $error("status pin idle during bus reset");
  chk_susp_cond: assert property (nrst && cfg_r[2] && cfg_r[0]
    && usb_suspended |=> usb_status_out)
    else $error("status pin idle while suspended");
  chk_power_high: assert property (nrst && cfg_r[3] && cfg_r[0]
    && mp_r > UNIT_LOAD_LIMIT && !usb_configured |=> usb_status_out)
    else $error("status pin idle when unconfigured at high power");
  chk_power_low: assert property (cfg_r == 4'h9 && mp_r <= UNIT_LOAD_LIMIT
    |=> usb_status_out == $past(usb_suspended))
    else $error("low power status does not track suspend");
  chk_none_idle: assert property (nrst && !cond
    |=> usb_status_out == !$past(cfg_r[0]))
    else $error("status pin active with no condition");
  chk_reset_default: assert property ($rose(nrst)
    |=> usb_status_out == $past(usb_suspended))
    else $error("status pin default wrong");
  chk_pin_reset: assert property ($rose(nrst)
    |-> port_b_io_pullup == 4'hf && port_b_io_oe == 4'h0)
    else $error("pins not pulled-up inputs after reset");
  chk_dir_drive: assert property (fn_r[1] |=> port_b_io_oe[1] && !port_b_io_pullup[1]
    && port_b_io_out[1] == $past(uart_dir_ctl))
    else $error("direction pin not driven from uart");
  chk_clk_drive: assert property (fn_r[0] |=> port_b_io_oe[0]
    && port_b_io_out[0] == $past(clk_pulse_src))
    else $error("clock pin not driven from source");
  chk_rx_quiet: assert property ((fn_r[3] && !uart_rx_busy)[*3] |=> $stable(port_b_io_out[3]))
    else $error("rx indicator moved while idle");
  chk_tx_quiet: assert property ((fn_r[2] && !uart_tx_busy)[*3] |=> $stable(port_b_io_out[2]))
    else $error("tx indicator moved while idle");

  cov_power_hi: cover property (cfg_r[3] && mp_r > UNIT_LOAD_LIMIT && !usb_configured);
  cov_rx_blink: cover property (fn_r[3] && uart_rx_busy && $changed(port_b_io_out[3]));
  cov_dir_alt: cover property (fn_r[1] && uart_dir_ctl);
endmodule

bind usbsi_top usbsi_monitor #(.TOGGLE_CYC(TOGGLE_CYC)) u_mon (.*);

// ===== sim/tb.sv
module tb;
  import usbsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TC = 8;
  logic        core_clk, nrst, avs_read, avs_write, avs_waitrequest, usb_status_out;
  logic        usb_bus_reset, usb_suspended, usb_configured;
  logic        uart_rx_busy, uart_tx_busy, uart_dir_ctl, clk_pulse_src;
  logic [7:0]  avs_address, m;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, c, prev;
  logic [3:0]  port_b_io_in, port_b_io_out, port_b_io_oe, port_b_io_pullup;
  logic [31:0] exp_q[$];
  int          miscompares, cmp_count, seed, tx_tog, rx_tog, a0, b0;

  usbsi_top #(.TOGGLE_CYC(TC)) dut (.*);
  usbsi_board board (.io_out(port_b_io_out), .io_oe(port_b_io_oe),
    .io_pull(port_b_io_pullup), .io_in(port_b_io_in));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    cmp_count++;
    if (seen !== want)
    begin
      $display("[ERR] %s expected %h seen %h", what, want, seen);
      miscompares++;
    end
  endtask

  // Held until waitrequest is sampled low at a rising edge, released on that edge
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask

  // Read data taken at the accepting rising edge
  always @(posedge core_clk)
    if (avs_read && avs_waitrequest === 1'b0)
      check(avs_readdata, exp_q.pop_front(), "readdata");

  always @(negedge core_clk)
  begin
    prev <= port_b_io_out;
    tx_tog <= tx_tog + int'(prev[2] !== port_b_io_out[2]);
    rx_tog <= rx_tog + int'(prev[3] !== port_b_io_out[3]);
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    conclude();
  end

  initial
  begin
    seed = 68;
    {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {usb_bus_reset, usb_configured, uart_rx_busy, uart_tx_busy} = '0;
    {uart_dir_ctl, clk_pulse_src} = '0;
    avs_byteenable = 4'hf;
    usb_suspended = 1'b1;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    check(32'(usb_status_out), 32'h1, "status default");
    check(32'(port_b_io_pullup), 32'hf, "pullup default");
    check(32'(port_b_io_oe), 32'h0, "oe default");
    rd(OFS_STAT_CFG, 32'(RST_STAT_CFG));
    rd(OFS_MAX_POWER, 32'(RST_MAX_POWER));
    rd(8'h20, 32'h0);
    avs_byteenable <= 4'he;
    bus(1'b0, OFS_STAT_CFG, 32'h0);
    avs_byteenable <= 4'hf;
    bus(1'b0, OFS_USB_STATE, 32'h0);
    rd(OFS_STAT_CFG, 32'(RST_STAT_CFG));
    rd(OFS_USB_STATE, 32'ha);
    $display("test reset done");
    repeat (24)
    begin
      c = 4'($random(seed));
      m = 8'h30 + 8'($random(seed) & 7);
      bus(1'b0, OFS_STAT_CFG, 32'(c));
      bus(1'b0, OFS_MAX_POWER, 32'(m));
      {usb_bus_reset, usb_suspended, usb_configured} <= 3'($random(seed));
      @(posedge core_clk);
      @(negedge core_clk);
      check(32'(usb_status_out), 32'(c[0] ^ !((c[1] & usb_bus_reset) | (c[2] & usb_suspended)
        | (c[3] & (usb_suspended | (m > 8'h32 & !usb_configured))))), "status");
      rd(OFS_STAT_CFG, 32'(c));
    end
    $display("test status done");
    bus(1'b0, OFS_PIN_FUNC, 32'hf);
    uart_dir_ctl <= 1'b1;
    clk_pulse_src <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    check(32'(port_b_io_oe), 32'hf, "alt oe");
    check(32'(port_b_io_out[1:0]), 32'h3, "alt drive");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge core_clk);
      a0 = tx_tog;
      b0 = rx_tog;
      uart_tx_busy <= (i == 0);
      uart_rx_busy <= (i == 1);
      repeat (3 * TC + TC / 2) @(posedge core_clk);
      uart_tx_busy <= 1'b0;
      uart_rx_busy <= 1'b0;
      repeat (4) @(posedge core_clk);
      check(32'(tx_tog - a0), (i == 0) ? 32'h3 : 32'h0, "tx toggles");
      check(32'(rx_tog - b0), (i == 1) ? 32'h3 : 32'h0, "rx toggles");
    end
    $display("test pins done");
    bus(1'b0, OFS_PIN_FUNC, 32'h0);
    bus(1'b0, OFS_GPIO_DIR, 32'h3);
    bus(1'b0, OFS_GPIO_OUT, 32'h1);
    repeat (4) @(posedge core_clk);
    rd(OFS_GPIO_IN, 32'hd);
    bus(1'b0, OFS_GPIO_PULL, 32'h0);
    repeat (4) @(posedge core_clk);
    check(32'(port_b_io_pullup), 32'h0, "pullup off");
    rd(OFS_GPIO_IN, 32'h1);
    $display("test gpio done");
    conclude();
  end
endmodule
